// File: design/bus_steer_pkg.sv
// Shared constants and types for both ends of the expansion bus steering.
package bus_steer_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned STAT_W = 8;
  localparam int unsigned CMD_OUT_W = 6;
  localparam int unsigned CMD_IN_W = 3;
  localparam int unsigned DIS_W = 4;
  localparam int unsigned WAIT_W = 2;
  localparam int unsigned CTRL_W = 28;
  // Internal memory occupies pages 0xc0..0xcf (four high address bits).
  localparam logic [5:0] INT_MEM_PAGE_HI = 6'h30;
  localparam int unsigned PAGE_MSB = 15;
  localparam int unsigned PAGE_LSB = 10;
  localparam int unsigned PORT_MSB = 15;
  localparam int unsigned PORT_LSB = 8;
  // Page decode for memory internal reads; display ram is written only.
  localparam logic [1:0] PAGE_DISPLAY = 2'h3;
  // I/O port numbers for on-board sources.
  localparam logic [7:0] PORT_SERIAL_STAT = 8'hf8;
  localparam logic [7:0] PORT_SERIAL_DATA = 8'hf9;
  localparam logic [7:0] PORT_CASS_STAT = 8'hfa;
  localparam logic [7:0] PORT_CASS_DATA = 8'hfb;
  localparam logic [7:0] PORT_KEYBOARD = 8'hfc;
  localparam logic [7:0] PORT_PARALLEL = 8'hfd;
  localparam logic [7:0] PORT_SWITCHES = 8'hff;
  // Page inhibited by the fifth disable line.
  localparam logic [5:0] INHIBIT_PAGE = 6'h00;

  typedef enum logic [3:0] {
    SEL_KEYBOARD = 4'h1,
    SEL_PARALLEL = 4'h2,
    SEL_BIDIR = 4'h4,
    SEL_INTERNAL = 4'h8
  } sel_t;

  typedef enum logic [1:0] {
    CYC_MEM_READ = 2'h0,
    CYC_IO_READ = 2'h1,
    CYC_WRITE = 2'h2,
    CYC_IDLE = 2'h3
  } cyc_t;
endpackage : bus_steer_pkg

// File: design/expansion_bus_if.sv
// Expansion bus joining the processor-side steering end and a DMA or module end.
`timescale 1ns/1ps
interface expansion_bus_if;
  import bus_steer_pkg::*;
  logic [ADDR_W-1:0] system_address_lines_o;
  logic system_address_lines_oe;
  logic [ADDR_W-1:0] dma_address_o;
  logic dma_address_oe;
  logic [DATA_W-1:0] cpu_data_o;
  logic cpu_data_oe;
  logic [DATA_W-1:0] dev_data_o;
  logic dev_data_oe;
  logic [STAT_W-1:0] cpu_status;
  logic cpu_status_oe;
  logic [STAT_W-1:0] dma_status;
  logic [CMD_OUT_W-1:0] cpu_cmd;
  logic cpu_cmd_oe;
  logic [CMD_OUT_W-1:0] dma_cmd;
  logic [CMD_IN_W-1:0] dev_cmd_ret;
  logic [DIS_W-1:0] disable_lines;
  logic page_inhibit;
  logic [WAIT_W-1:0] wait_req;
  logic [ADDR_W-1:0] system_address_lines;
  logic [DATA_W-1:0] bidir_expansion_data;
  logic [DATA_W-1:0] bidir_expansion_data_copy;
  logic [STAT_W-1:0] status_lines;
  logic [CMD_OUT_W-1:0] cmd_lines;

  assign system_address_lines = system_address_lines_oe ? system_address_lines_o :
    (dma_address_oe ? dma_address_o : '0);
  assign bidir_expansion_data = cpu_data_oe ? cpu_data_o : (dev_data_oe ? dev_data_o : '0);
  assign bidir_expansion_data_copy = bidir_expansion_data;
  assign status_lines = cpu_status_oe ? cpu_status : dma_status;
  assign cmd_lines = cpu_cmd_oe ? cpu_cmd : dma_cmd;

  modport steer (
    output system_address_lines_o, system_address_lines_oe, cpu_data_o, cpu_data_oe,
    output cpu_status, cpu_status_oe, cpu_cmd, cpu_cmd_oe, page_inhibit,
    input bidir_expansion_data, dev_cmd_ret, disable_lines, wait_req, system_address_lines
  );
  modport far_end (
    output dma_address_o, dma_address_oe, dev_data_o, dev_data_oe, dma_status, dma_cmd,
    output dev_cmd_ret, disable_lines, wait_req,
    input system_address_lines, bidir_expansion_data, bidir_expansion_data_copy,
    input status_lines, cmd_lines, page_inhibit
  );
endinterface : expansion_bus_if

// File: design/cpu_bus_steer.sv
// Processor-side data steering and tri-state buffering for the expansion bus.
// Function
// RULE_01: Four-way selector feeds processor input data.
// RULE_02: On-board memory, serial, cassette reads use internal bus.
// RULE_03: All write data goes on expansion bus.
// RULE_04: Switches and external reads use expansion input; switch reads here take option_switches directly instead.
// RULE_05: Address and data outputs are tri-state buffered.
// RULE_06: DMA master drives all sixteen address lines.
// RULE_07: Eight status lines, driven by DMA during DMA.
// RULE_08: Nine command lines, six out, three back.
// RULE_09: Four disable lines release processor-side drivers.
// RULE_10: Fifth disable from read strobe, jumper optional.
// RULE_11: Two separate wait inputs stretch the cycle.
// RULE_12: Expansion data duplicated on second eight lines.
// RULE_13: Serial and cassette drive internal bus directly.
// RULE_14: Keyboard, parallel, switch, internal eight-bit ports.
// RULE_15: Sixteen address, eight data, 28 control lines.
// RULE_16: Exactly one selector source per read.
`timescale 1ns/1ps
module cpu_bus_steer
  import bus_steer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  expansion_bus_if.steer bus,
  input wire logic [ADDR_W-1:0] cpu_address,
  input wire logic [DATA_W-1:0] cpu_write_data,
  input wire logic [STAT_W-1:0] cpu_status_in,
  input wire logic [CMD_OUT_W-1:0] cpu_cmd_in,
  input wire logic cpu_read_strobe,
  input wire logic cpu_write_strobe,
  input wire logic cpu_io_cycle,
  input wire logic inhibit_jumper,
  input wire logic [DATA_W-1:0] keyboard_input_lines,
  input wire logic [DATA_W-1:0] parallel_input_lines,
  input wire logic [DATA_W-1:0] option_switches,
  input wire logic [DATA_W-1:0] internal_input_bus,
  input wire logic [DATA_W-1:0] parallel_out_data,
  output logic [DATA_W-1:0] cpu_read_data,
  output logic [3:0] read_source,
  output logic cpu_wait,
  output logic [CMD_IN_W-1:0] cmd_return,
  output logic [DATA_W-1:0] parallel_output_lines,
  output logic [DATA_W-1:0] switch_bus_data,
  output logic switch_bus_oe
);
  import bus_steer_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic addr_oe;
    logic [DATA_W-1:0] wdata;
    logic data_oe;
    logic [STAT_W-1:0] stat;
    logic [CMD_OUT_W-1:0] cmd;
    logic ctl_oe;
    logic inhibit;
    logic [DATA_W-1:0] rdata;
    sel_t sel;
    logic wt;
    logic [CMD_IN_W-1:0] ret;
    logic [DATA_W-1:0] pout;
    logic [DATA_W-1:0] sw;
    logic sw_oe;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic released;
  logic [5:0] page;
  logic [7:0] port;
  logic internal_hit;

  always_comb begin
    st_nxt = st_r;
    page = cpu_address[PAGE_MSB:PAGE_LSB];
    port = cpu_address[PORT_MSB:PORT_LSB];
    released = |bus.disable_lines; // [RULE_09] [RULE_06]
    // On-board rom and system ram answer on the internal bus; display ram is write only.
    internal_hit = cpu_io_cycle ?
      (port == PORT_SERIAL_STAT || port == PORT_SERIAL_DATA ||
       port == PORT_CASS_STAT || port == PORT_CASS_DATA) :
      (page[5:2] == INT_MEM_PAGE_HI[5:2] && page[1:0] != PAGE_DISPLAY); // [RULE_02] [RULE_13]
    st_nxt.addr = cpu_address;
    st_nxt.addr_oe = !released; // [RULE_05] [RULE_15]
    st_nxt.wdata = cpu_write_data;
    st_nxt.data_oe = !released && cpu_write_strobe; // [RULE_03] [RULE_05]
    st_nxt.stat = cpu_status_in;
    st_nxt.cmd = cpu_cmd_in;
    st_nxt.ctl_oe = !released; // [RULE_07] [RULE_08]
    st_nxt.inhibit = inhibit_jumper && cpu_read_strobe && page == INHIBIT_PAGE; // [RULE_10]
    st_nxt.ret = bus.dev_cmd_ret; // [RULE_08]
    st_nxt.wt = |bus.wait_req; // [RULE_11]
    st_nxt.pout = parallel_out_data; // [RULE_14]
    st_nxt.sw_oe = cpu_read_strobe && cpu_io_cycle && port == PORT_SWITCHES; // [RULE_04]
    st_nxt.sw = option_switches;
    // One source only: the priority order makes the choice unique.
    if (cpu_io_cycle && port == PORT_KEYBOARD) begin
      st_nxt.sel = SEL_KEYBOARD;
    end else if (cpu_io_cycle && port == PORT_PARALLEL) begin
      st_nxt.sel = SEL_PARALLEL;
    end else if (internal_hit) begin
      st_nxt.sel = SEL_INTERNAL;
    end else begin
      st_nxt.sel = SEL_BIDIR; // [RULE_04] [RULE_12]
    end // [RULE_16]
    unique case (st_nxt.sel)
      SEL_KEYBOARD: st_nxt.rdata = keyboard_input_lines;
      SEL_PARALLEL: st_nxt.rdata = parallel_input_lines;
      SEL_INTERNAL: st_nxt.rdata = internal_input_bus;
      // The switch array is not wired onto the expansion data input here, so its byte is taken directly from option_switches.
      SEL_BIDIR: st_nxt.rdata = (cpu_io_cycle && port == PORT_SWITCHES) ? option_switches :
        bus.bidir_expansion_data; // [RULE_04]
    endcase // [RULE_01]
    if (!cpu_read_strobe) begin
      st_nxt.rdata = st_r.rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '{sel: SEL_BIDIR, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.system_address_lines_o = st_r.addr;
  assign bus.system_address_lines_oe = st_r.addr_oe;
  assign bus.cpu_data_o = st_r.wdata;
  assign bus.cpu_data_oe = st_r.data_oe;
  assign bus.cpu_status = st_r.stat;
  assign bus.cpu_status_oe = st_r.ctl_oe;
  assign bus.cpu_cmd = st_r.cmd;
  assign bus.cpu_cmd_oe = st_r.ctl_oe;
  assign bus.page_inhibit = st_r.inhibit;
  assign cpu_read_data = st_r.rdata;
  assign read_source = st_r.sel;
  assign cpu_wait = st_r.wt;
  assign cmd_return = st_r.ret;
  assign parallel_output_lines = st_r.pout;
  assign switch_bus_data = st_r.sw;
  assign switch_bus_oe = st_r.sw_oe;
endmodule : cpu_bus_steer

// File: design/dma_bus_end.sv
// Expansion-side end: a DMA master and a memory or I/O module responder.
`timescale 1ns/1ps
module dma_bus_end
  import bus_steer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  expansion_bus_if.far_end bus,
  input wire logic dma_request,
  input wire logic [ADDR_W-1:0] dma_address,
  input wire logic [STAT_W-1:0] dma_status_in,
  input wire logic [CMD_OUT_W-1:0] dma_cmd_in,
  input wire logic [DATA_W-1:0] dma_write_data,
  input wire logic dma_write,
  input wire logic [DATA_W-1:0] module_read_data,
  input wire logic module_read_enable,
  input wire logic [CMD_IN_W-1:0] module_cmd_ret,
  input wire logic module_wait,
  input wire logic external_wait,
  output logic dma_granted,
  output logic [DATA_W-1:0] dma_read_data
);
  import bus_steer_pkg::*;

  typedef struct packed {
    logic own;
    logic [ADDR_W-1:0] addr;
    logic [STAT_W-1:0] stat;
    logic [CMD_OUT_W-1:0] cmd;
    logic [DATA_W-1:0] wdata;
    logic doe;
    logic [CMD_IN_W-1:0] ret;
    logic [WAIT_W-1:0] wt;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.own = dma_request; // [RULE_09]
    st_nxt.addr = dma_address; // [RULE_06]
    st_nxt.stat = dma_status_in; // [RULE_07]
    st_nxt.cmd = dma_cmd_in; // [RULE_08]
    st_nxt.wdata = dma_request ? dma_write_data : module_read_data;
    st_nxt.doe = (dma_request && dma_write) || (module_read_enable && !bus.page_inhibit); // [RULE_10]
    st_nxt.ret = module_cmd_ret; // [RULE_08]
    st_nxt.wt = {external_wait, module_wait}; // [RULE_11]
    st_nxt.rdata = bus.bidir_expansion_data_copy; // [RULE_12]
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.disable_lines = {DIS_W{st_r.own}}; // [RULE_09]
  assign bus.dma_address_o = st_r.addr;
  assign bus.dma_address_oe = st_r.own; // [RULE_06]
  assign bus.dma_status = st_r.stat;
  assign bus.dma_cmd = st_r.cmd;
  assign bus.dev_data_o = st_r.wdata;
  assign bus.dev_data_oe = st_r.doe;
  assign bus.dev_cmd_ret = st_r.ret;
  assign bus.wait_req = st_r.wt;
  assign dma_granted = st_r.own;
  assign dma_read_data = st_r.rdata;
endmodule : dma_bus_end

// File: verif/bus_steer_properties.sv
// Concurrent checks on the expansion bus between the two ends.
`timescale 1ns/1ps
module bus_steer_properties
  import bus_steer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [DIS_W-1:0] disable_lines,
  input wire logic system_address_lines_oe,
  input wire logic cpu_data_oe,
  input wire logic cpu_status_oe,
  input wire logic cpu_cmd_oe,
  input wire logic dma_address_oe,
  input wire logic [STAT_W-1:0] status_lines,
  input wire logic [STAT_W-1:0] dma_status,
  input wire logic [CMD_OUT_W-1:0] cmd_lines,
  input wire logic [CMD_OUT_W-1:0] dma_cmd,
  input wire logic page_inhibit,
  input wire logic [ADDR_W-1:0] system_address_lines
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_DIS_ADDR: assert property (|disable_lines |=> !system_address_lines_oe)
    else $error("address driver stayed on");
  AST_DIS_DATA: assert property (|disable_lines |=> !cpu_data_oe)
    else $error("data driver stayed on");
  AST_DIS_STAT: assert property (|disable_lines |=> !cpu_status_oe)
    else $error("status driver stayed on");
  AST_DIS_CMD: assert property (|disable_lines |=> !cpu_cmd_oe)
    else $error("command driver stayed on");
  AST_DMA_ADDR: assert property ($rose(dma_address_oe) |-> disable_lines == 4'hf)
    else $error("dma address without all disables");
  AST_DMA_CMD: assert property ($rose(|disable_lines) |-> ##1 cmd_lines == dma_cmd)
    else $error("command lines not taken over");
  AST_DMA_STAT: assert property ((|disable_lines)[*2] |-> status_lines == dma_status)
    else $error("status lines not taken over");
  AST_INHIBIT: assert property (page_inhibit && system_address_lines_oe |->
    system_address_lines[PAGE_MSB:PAGE_LSB] == INHIBIT_PAGE)
    else $error("inhibit outside its page");
  cover property ($rose(dma_address_oe));
  cover property (page_inhibit);
  cover property (cpu_data_oe && !(|disable_lines));
endmodule : bus_steer_properties

// File: verif/tb_cpu_bus_data_steering.sv
// Self-checking bench for both ends of the expansion bus.
`timescale 1ns/1ps
module tb_cpu_bus_data_steering;
  import bus_steer_pkg::*;
  logic mclk = 1'h0, rst = 1'h1;
  logic [15:0] cpu_address = '0, dma_address = '0;
  logic [7:0] cpu_write_data = '0, cpu_status_in = '0, parallel_out_data = '0, dma_write_data = '0;
  logic [7:0] keyboard_input_lines = 8'h11, parallel_input_lines = 8'h22, option_switches = 8'h81;
  logic [7:0] internal_input_bus = 8'h44, module_read_data = '0, dma_status_in = '0;
  logic [5:0] cpu_cmd_in = '0, dma_cmd_in = '0;
  logic [2:0] module_cmd_ret = '0, cmd_return;
  logic cpu_read_strobe = 1'h0, cpu_write_strobe = 1'h0, cpu_io_cycle = 1'h0, inhibit_jumper = 1'h0;
  logic dma_request = 1'h0, dma_write = 1'h0, module_read_enable = 1'h0, module_wait = 1'h0, external_wait = 1'h0;
  logic [7:0] cpu_read_data, parallel_output_lines, switch_bus_data, dma_read_data;
  logic [3:0] read_source;
  logic cpu_wait, switch_bus_oe, dma_granted;
  int miscompares = 0, tests_run = 0;
  always #2 mclk = ~mclk;
  expansion_bus_if bus();
  cpu_bus_steer cpu_bus_steer_i (.mclk, .rst, .bus, .cpu_address, .cpu_write_data, .cpu_status_in, .cpu_cmd_in,
    .cpu_read_strobe, .cpu_write_strobe, .cpu_io_cycle, .inhibit_jumper, .keyboard_input_lines,
    .parallel_input_lines, .option_switches, .internal_input_bus, .parallel_out_data, .cpu_read_data,
    .read_source, .cpu_wait, .cmd_return, .parallel_output_lines, .switch_bus_data, .switch_bus_oe);
  dma_bus_end dma_bus_end_i (.mclk, .rst, .bus, .dma_request, .dma_address, .dma_status_in, .dma_cmd_in,
    .dma_write_data, .dma_write, .module_read_data, .module_read_enable, .module_cmd_ret, .module_wait,
    .external_wait, .dma_granted, .dma_read_data);
  bus_steer_properties bus_steer_properties_i (.mclk, .rst, .disable_lines(bus.disable_lines),
    .system_address_lines_oe(bus.system_address_lines_oe), .cpu_data_oe(bus.cpu_data_oe),
    .cpu_status_oe(bus.cpu_status_oe), .cpu_cmd_oe(bus.cpu_cmd_oe), .dma_address_oe(bus.dma_address_oe),
    .status_lines(bus.status_lines), .dma_status(bus.dma_status), .cmd_lines(bus.cmd_lines),
    .dma_cmd(bus.dma_cmd), .page_inhibit(bus.page_inhibit), .system_address_lines(bus.system_address_lines));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // The module answer crosses two registers, so a read is held three cycles.
  task automatic rd(input logic io, input logic [15:0] a, input logic [3:0] src, input logic [7:0] d);
    cpu_io_cycle = io;
    cpu_address = a;
    cpu_read_strobe = 1'h1;
    cyc(3);
    chk("source", read_source, src);
    chk("read data", cpu_read_data, d);
    cpu_read_strobe = 1'h0;
    cyc(1);
  endtask : rd
  task automatic t_ports();
    rd(1'h1, 16'hfc00, 4'h1, 8'h11);
    rd(1'h1, 16'hfd00, 4'h2, 8'h22);
    rd(1'h1, 16'hf900, 4'h8, 8'h44);
    rd(1'h1, 16'hfa00, 4'h8, 8'h44);
    cpu_address = 16'hff00;
    cpu_read_strobe = 1'h1;
    cyc(3);
    chk("switch source", read_source, 4'h4);
    chk("switch data", switch_bus_data, 8'h81);
    chk("switch enable", switch_bus_oe, 1'h1);
    chk("switch read", cpu_read_data, 8'h81);
    cpu_read_strobe = 1'h0;
    cyc(1);
  endtask : t_ports
  task automatic t_mem();
    rd(1'h0, 16'hc123, 4'h8, 8'h44);
    rd(1'h0, 16'hc834, 4'h8, 8'h44);
    module_read_data = 8'h5a;
    module_read_enable = 1'h1;
    rd(1'h0, 16'hcc10, 4'h4, 8'h5a);
    rd(1'h0, 16'h4000, 4'h4, 8'h5a);
    module_read_enable = 1'h0;
  endtask : t_mem
  task automatic t_write();
    for (int i = 0; i < 2; i++) begin
      cpu_address = i ? 16'h1234 : 16'hc800;
      cpu_write_data = i ? 8'h3c : 8'hc3;
      cpu_write_strobe = 1'h1;
      cyc(2);
      chk("write bus", bus.bidir_expansion_data, cpu_write_data);
      chk("address", bus.system_address_lines, cpu_address);
      cyc(1);
      chk("copy lines", dma_read_data, cpu_write_data);
    end
    cpu_write_strobe = 1'h0;
  endtask : t_write
  task automatic t_dma();
    dma_address = 16'habcd;
    dma_status_in = 8'h5c;
    dma_cmd_in = 6'h2a;
    dma_request = 1'h1;
    for (int i = 0; i < 8 && dma_granted !== 1'h1; i++)
      cyc(1);
    if (dma_granted !== 1'h1) begin
      miscompares++;
      conclude();
    end
    cyc(2);
    chk("disables", bus.disable_lines, 4'hf);
    chk("dma address", bus.system_address_lines, 16'habcd);
    chk("status", bus.status_lines, 8'h5c);
    chk("command", bus.cmd_lines, 6'h2a);
    chk("data released", bus.cpu_data_oe, 1'h0);
    dma_request = 1'h0;
    cyc(4);
  endtask : t_dma
  task automatic t_ctrl();
    module_cmd_ret = 3'h5;
    module_wait = 1'h1;
    cyc(3);
    chk("return", cmd_return, 3'h5);
    chk("module wait", cpu_wait, 1'h1);
    module_wait = 1'h0;
    external_wait = 1'h1;
    cyc(3);
    chk("external wait", cpu_wait, 1'h1);
    external_wait = 1'h0;
    cyc(3);
    chk("no wait", cpu_wait, 1'h0);
    parallel_out_data = 8'h7e;
    cyc(2);
    chk("parallel out", parallel_output_lines, 8'h7e);
    inhibit_jumper = 1'h1;
    cpu_address = 16'h0010;
    cpu_read_strobe = 1'h1;
    module_read_data = 8'h5a;
    module_read_enable = 1'h1;
    cyc(2);
    chk("inhibit", bus.page_inhibit, 1'h1);
    chk("inhibited data", bus.bidir_expansion_data, 8'h00);
    module_read_enable = 1'h0;
    inhibit_jumper = 1'h0;
    cyc(2);
    chk("jumper off", bus.page_inhibit, 1'h0);
    cpu_read_strobe = 1'h0;
  endtask : t_ctrl
  initial begin
    cyc(5);
    rst = 1'h0;
    cyc(1);
    t_ports();
    t_mem();
    t_write();
    t_dma();
    t_ctrl();
    conclude();
  end
endmodule : tb_cpu_bus_data_steering
